// [hw/ramcol_defs.svh]
// ramcol_defs.svh: widths, register offsets, field positions, reset values, timing counts
// assumes: included by bare name from the package file only; later design files rely on its macros
`ifndef RAMCOL_DEFS_SVH
`define RAMCOL_DEFS_SVH
`define RAMCOL_ADDR_W 8
`define RAMCOL_DATA_W 9
`define RAMCOL_DEPTH 256
`define RAMCOL_CTRL_W 5
`define RAMCOL_REG_CTRL 8'h00
`define RAMCOL_REG_STAT 8'h04
`define RAMCOL_CTRL_WASYNC 0
`define RAMCOL_CTRL_RASYNC 1
`define RAMCOL_CTRL_PIPE 2
`define RAMCOL_CTRL_PGEN 3
`define RAMCOL_CTRL_PODD 4
`define RAMCOL_CTRL_RST 5'h00
`define RAMCOL_STAT_ACT 9
`define RAMCOL_STAT_RPE 10
`define RAMCOL_STAT_WPE 11
`define RAMCOL_PIN_RST 8'h3F
`define RAMCOL_CLK_PS 25000
`define RAMCOL_RD_LOW_PS 3000
`define RAMCOL_RD_PHASE_CYC ((`RAMCOL_RD_LOW_PS + `RAMCOL_CLK_PS - 1) / `RAMCOL_CLK_PS)
`endif

// [hw/ramcol_pkg.sv]
// ramcol_pkg: state types of the two-port ram block
// assumes: ramcol_defs.svh on the include path
`include "ramcol_defs.svh"
package ramcol_pkg;
  typedef enum logic [0:0] {RC_IDLE, RC_ACT} ramcol_rd_t;
  typedef struct packed {
    logic [`RAMCOL_DEPTH-1:0][`RAMCOL_DATA_W-1:0] mem;
    logic [`RAMCOL_CTRL_W-1:0] ctrl;
    logic wclk_d;
    logic rclk_d;
    logic wstb_d;
    logic aw_act;
    logic [`RAMCOL_ADDR_W-1:0] aw_addr;
    ramcol_rd_t rd_st;
    logic [3:0] rd_cnt;
    logic [`RAMCOL_DATA_W-1:0] pipe;
    logic [`RAMCOL_DATA_W-1:0] dout;
    logic read_parity_fault;
    logic write_parity_fault;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ramcol_state_t;
endpackage : ramcol_pkg

// [hw/ramcol_sync3.sv]
// ramcol_sync3: three-stage pin synchroniser, a bit changes once stages two and three agree
// assumes: inputs asynchronous to CLK_SYS_I
`timescale 1ns/100ps
module ramcol_sync3 #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ramcol_syn_t;
  ramcol_syn_t s_r;
  ramcol_syn_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // stage one is read only by stage two
    s_nxt.q = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.q & (s_r.s2 ^ s_r.s3));
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
  assign q_o = s_r.q;
endmodule : ramcol_sync3

// [hw/ramcol_parity.sv]
// ramcol_parity: parity bit generation and check, msb holds parity
// assumes: odd_i high selects odd parity
`timescale 1ns/100ps
module ramcol_parity #(
  parameter int W = 9
) (
  // word and sense
  input wire logic [W-1:0] data_i,
  input wire logic odd_i,
  // results
  output logic gen_o,
  output logic err_o
);
  assign gen_o = (^data_i[W-2:0]) ^ odd_i;
  assign err_o = (^data_i) ^ odd_i;
endmodule : ramcol_parity

// [hw/ramcol_top.sv]
// ramcol_top: 256x9 two-port ram with same-address collision handling, apb config/status
// assumes: user pins asynchronous to CLK_SYS_I; apb master on CLK_SYS_I
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
module ramcol_top
  import ramcol_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // write side pins
  input wire logic WRITE_SIDE_CLOCK_I,
  input wire logic WRITE_STROBE_N_I,
  input wire logic WRITE_PULSE_N_I,
  input wire logic WRITE_SELECT_N_I,
  input wire logic [7:0] WRITE_LOCATION_I,
  input wire logic [8:0] WRITE_WORD_IN_I,
  output logic WRITE_PARITY_FAULT_O,
  // read side pins
  input wire logic READ_SIDE_CLOCK_I,
  input wire logic READ_STROBE_N_I,
  input wire logic READ_PULSE_N_I,
  input wire logic READ_SELECT_N_I,
  input wire logic [7:0] READ_LOCATION_I,
  output logic [8:0] READ_WORD_O,
  output logic READ_PARITY_FAULT_O
);
  localparam logic [3:0] RD_PHASE = 4'(`RAMCOL_RD_PHASE_CYC);

  ramcol_state_t s_r;
  ramcol_state_t s_nxt;

  logic [7:0] ctl_pins;
  logic [24:0] bus_pins;
  logic wclk;
  logic rclk;
  logic wstb_n;
  logic wpls_n;
  logic rstb_n;
  logic rpls_n;
  logic wsel_n;
  logic rsel_n;
  logic [`RAMCOL_ADDR_W-1:0] write_location;
  logic [`RAMCOL_ADDR_W-1:0] read_location;
  logic [`RAMCOL_DATA_W-1:0] wd;

  // both groups see the same depth so address and strobes line up
  ramcol_sync3 #(.W(8), .RST_VAL(`RAMCOL_PIN_RST)) u_sync_ctl (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .d_i({WRITE_SIDE_CLOCK_I, READ_SIDE_CLOCK_I, WRITE_STROBE_N_I, WRITE_PULSE_N_I,
          READ_STROBE_N_I, READ_PULSE_N_I, WRITE_SELECT_N_I, READ_SELECT_N_I}),
    .q_o(ctl_pins)
  );
  ramcol_sync3 #(.W(25), .RST_VAL(25'h0)) u_sync_bus (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .d_i({WRITE_LOCATION_I, READ_LOCATION_I, WRITE_WORD_IN_I}),
    .q_o(bus_pins)
  );
  assign {wclk, rclk, wstb_n, wpls_n, rstb_n, rpls_n, wsel_n, rsel_n} = ctl_pins;
  assign {write_location, read_location, wd} = bus_pins;

  // configuration
  logic wasync;
  logic rasync;
  logic pipe_mode;
  logic pgen;
  logic podd;
  assign wasync = s_r.ctrl[`RAMCOL_CTRL_WASYNC];
  assign rasync = s_r.ctrl[`RAMCOL_CTRL_RASYNC];
  assign pipe_mode = s_r.ctrl[`RAMCOL_CTRL_PIPE];
  assign pgen = s_r.ctrl[`RAMCOL_CTRL_PGEN];
  assign podd = s_r.ctrl[`RAMCOL_CTRL_PODD];

  // edges of the synchronised pins
  logic wclk_rise;
  logic rclk_rise;
  logic wstb_fall;
  logic wstb_rise;
  assign wclk_rise = wclk & ~s_r.wclk_d;
  assign rclk_rise = rclk & ~s_r.rclk_d;
  assign wstb_fall = ~wstb_n & s_r.wstb_d;
  assign wstb_rise = wstb_n & ~s_r.wstb_d;

  // write side
  logic wgen;
  logic werr;
  logic [`RAMCOL_DATA_W-1:0] wdata;
  logic sync_wr;
  logic aw_start;
  logic aw_end;
  logic wr_commit;
  logic [`RAMCOL_ADDR_W-1:0] wr_addr;
  ramcol_parity #(.W(`RAMCOL_DATA_W)) u_wpar (
    .data_i(wd),
    .odd_i(podd),
    .gen_o(wgen),
    .err_o(werr)
  );
  assign wdata = pgen ? {wgen, wd[`RAMCOL_DATA_W-2:0]} : wd;
  assign sync_wr = ~wasync & wclk_rise & ~wpls_n & ~wsel_n;
  assign aw_start = wasync & wstb_fall & ~wsel_n;
  assign aw_end = wasync & wstb_rise & s_r.aw_act;
  assign wr_commit = sync_wr | aw_end;
  assign wr_addr = sync_wr ? write_location : s_r.aw_addr;

  // read side
  logic sync_rd;
  logic rd_req;
  logic aw_open_hit;
  logic coll;
  logic [`RAMCOL_DATA_W-1:0] fresh;
  logic [`RAMCOL_DATA_W-1:0] async_word;
  logic [`RAMCOL_DATA_W-1:0] load_word;
  logic load_en;
  logic rd_act;
  logic rgen_unused;
  logic rerr;
  assign sync_rd = ~rasync & rclk_rise & ~rpls_n & ~rsel_n;
  assign rd_req = rasync & ~rstb_n & ~rsel_n;
  assign rd_act = (s_r.rd_st == RC_ACT) & rd_req;
  // strobe already low, or falling in this very cycle, counts as earlier
  assign aw_open_hit = s_r.aw_act ? (s_r.aw_addr == read_location) : (aw_start & (write_location == read_location));
  // a write edge in the same sample as the read edge wins
  assign coll = (sync_wr & (write_location == read_location)) | aw_open_hit;
  // later writes never reach this read: old word
  assign fresh = coll ? wdata : s_r.mem[read_location];
  assign async_word = (wr_commit & (wr_addr == read_location)) ? wdata : s_r.mem[read_location];
  assign load_word = rd_act ? async_word : (pipe_mode ? s_r.pipe : fresh);
  assign load_en = rd_act | sync_rd;
  ramcol_parity #(.W(`RAMCOL_DATA_W)) u_rpar (
    .data_i(load_word),
    .odd_i(podd),
    .gen_o(rgen_unused),
    .err_o(rerr)
  );

  // apb decode
  logic ctrl_hit;
  logic stat_hit;
  logic [31:0] stat_word;
  assign ctrl_hit = PADDR_I == `RAMCOL_REG_CTRL;
  assign stat_hit = PADDR_I == `RAMCOL_REG_STAT;
  assign stat_word = {20'h0, s_r.write_parity_fault, s_r.read_parity_fault, s_r.rd_st == RC_ACT, s_r.dout};

  always_comb begin
    s_nxt = s_r;
    s_nxt.wclk_d = wclk;
    s_nxt.rclk_d = rclk;
    s_nxt.wstb_d = wstb_n;
    // no wait state: ready is registered from the setup cycle, high in the first access cycle
    s_nxt.pready = 1'b0;
    if (PSEL_I && !PENABLE_I && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !(ctrl_hit || stat_hit);
      s_nxt.prdata = 32'h0;
      if (ctrl_hit) begin
        s_nxt.prdata = {27'h0, s_r.ctrl};
      end else if (stat_hit) begin
        s_nxt.prdata = stat_word;
      end
    end
    if (PSEL_I && PENABLE_I && s_r.pready && PWRITE_I && ctrl_hit) begin
      s_nxt.ctrl = PWDATA_I[`RAMCOL_CTRL_W-1:0];
    end
    // async write: address held from strobe fall, data taken at rise
    if (aw_start) begin
      s_nxt.aw_act = 1'b1;
      s_nxt.aw_addr = write_location;
    end else if (aw_end || !wasync) begin
      s_nxt.aw_act = 1'b0;
    end
    if (wr_commit) begin
      s_nxt.mem[wr_addr] = wdata;
    end
    // fault meaningless while generating, forced low
    if (pgen) begin
      s_nxt.write_parity_fault = 1'b0;
    end else if (wasync || wclk_rise) begin
      s_nxt.write_parity_fault = werr;
    end
    case (s_r.rd_st)
      RC_IDLE: begin
        if (rd_req) begin
          if (s_r.rd_cnt != 4'hF) begin
            s_nxt.rd_cnt = s_r.rd_cnt + 4'h1;
          end
          if (s_r.rd_cnt >= RD_PHASE - 4'h1) begin
            s_nxt.rd_st = RC_ACT;
          end
        end else begin
          s_nxt.rd_cnt = 4'h0;
        end
      end
      RC_ACT: begin
        if (!rd_req) begin
          s_nxt.rd_st = RC_IDLE;
          s_nxt.rd_cnt = 4'h0;
        end
      end
      default: begin
        s_nxt.rd_st = RC_IDLE;
      end
    endcase
    if (load_en) begin
      s_nxt.dout = load_word;
      s_nxt.read_parity_fault = rerr;
      if (sync_rd) begin
        s_nxt.pipe = fresh;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_r <= '0;
      s_r.ctrl <= `RAMCOL_CTRL_RST;
      s_r.wstb_d <= 1'b1;
      s_r.rd_st <= RC_IDLE;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O = s_r.prdata;
  assign PREADY_O = s_r.pready;
  assign PSLVERR_O = s_r.pslverr;
  assign READ_WORD_O = s_r.dout;
  assign READ_PARITY_FAULT_O = s_r.read_parity_fault;
  assign WRITE_PARITY_FAULT_O = s_r.write_parity_fault;

  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  sequence s_tr_read;
    CE_I && sync_rd && !pipe_mode;
  endsequence
  sequence s_async_hold;
    CE_I && rd_act;
  endsequence

  a_sync_forward: assert property (
    s_tr_read ##0 (sync_wr && write_location == read_location) |=> READ_WORD_O == $past(wdata))
    else $error("same-address sync write not forwarded");
  a_old_word: assert property (
    s_tr_read ##0 !coll |=> READ_WORD_O == $past(s_r.mem[read_location]))
    else $error("read without collision did not return stored word");
  a_async_wr_new: assert property (
    s_tr_read ##0 (wasync && s_r.aw_act && s_r.aw_addr == read_location) |=> READ_WORD_O == $past(wdata))
    else $error("open async write not returned to sync read");
  a_pipe_delay: assert property (
    CE_I && sync_rd && pipe_mode |=> READ_WORD_O == $past(s_r.pipe) && s_r.pipe == $past(fresh))
    else $error("pipelined output not one read cycle behind");
  a_wpe_quiet: assert property (
    CE_I && pgen |=> !WRITE_PARITY_FAULT_O)
    else $error("write parity fault raised while generating");
  a_rpe_follow: assert property (
    CE_I && load_en |=> READ_PARITY_FAULT_O == ((^READ_WORD_O) ^ $past(podd)))
    else $error("read parity fault not matching word");
  a_async_refresh: assert property (
    s_async_hold ##0 (sync_wr && write_location == read_location) |=> READ_WORD_O == $past(wdata))
    else $error("write during async read did not refresh output");
  a_async_end_new: assert property (
    s_async_hold ##0 (aw_end && s_r.aw_addr == read_location) |=> READ_WORD_O == $past(wdata))
    else $error("async write end did not drive new word");
  a_strobe_phase: assert property (
    CE_I && s_r.rd_st == RC_ACT && !rd_req |=> s_r.rd_st == RC_IDLE ##1 !CE_I || rd_req || s_r.rd_st == RC_IDLE)
    else $error("async read stayed active after strobe high");
  a_sync_store: assert property (
    CE_I && sync_wr |=> s_r.mem[$past(write_location)] == $past(wdata))
    else $error("sync write not stored");
endmodule : ramcol_top

// [sim/ramcol_user.sv]
// ramcol_user: user logic in the fabric driving both ram sides
// assumes: clk_i is the system clock; pins are sampled by three flops
`timescale 1ns/100ps
module ramcol_user (
  // clock
  input wire logic clk_i,
  // write side
  output logic wclk_o,
  output logic wstb_n_o,
  output logic wpul_n_o,
  output logic wsel_n_o,
  output logic [7:0] wloc_o,
  output logic [8:0] wdat_o,
  // read side
  output logic rclk_o,
  output logic rstb_n_o,
  output logic rpul_n_o,
  output logic rsel_n_o,
  output logic [7:0] rloc_o
);
  initial begin
    {wclk_o, rclk_o} = 2'h0;
    {wstb_n_o, wpul_n_o, wsel_n_o, rstb_n_o, rpul_n_o, rsel_n_o} = 6'h3F;
    wloc_o = 8'h00;
    wdat_o = 9'h000;
    rloc_o = 8'h00;
  end
  // four cycles keep pins clear of the sampling window
  task gap();
    repeat (4) @(posedge clk_i);
  endtask : gap
  task cyc(input logic wr, input logic rd, input logic [7:0] wa, input logic [7:0] ra,
           input logic [8:0] d);
    wpul_n_o <= ~wr;
    wsel_n_o <= ~wr;
    rpul_n_o <= ~rd;
    rsel_n_o <= ~rd;
    wloc_o <= wa;
    rloc_o <= ra;
    if (wr) wdat_o <= d;
    gap();
    wclk_o <= wr;
    rclk_o <= rd;
    gap();
    {wclk_o, rclk_o} <= 2'h0;
    gap();
    {wpul_n_o, wsel_n_o, rpul_n_o, rsel_n_o} <= 4'hF;
    // released data must not look held
    if (wr) wdat_o <= ~d;
    gap();
  endtask : cyc
  task awf(input logic [7:0] wa, input logic [8:0] d);
    wsel_n_o <= 1'b0;
    wloc_o <= wa;
    wdat_o <= d;
    gap();
    wstb_n_o <= 1'b0;
    gap();
  endtask : awf
  task awr();
    wstb_n_o <= 1'b1;
    gap();
    wsel_n_o <= 1'b1;
    wdat_o <= ~wdat_o;
    gap();
  endtask : awr
  task arf(input logic [7:0] ra);
    rsel_n_o <= 1'b0;
    rloc_o <= ra;
    gap();
    rstb_n_o <= 1'b0;
    gap();
  endtask : arf
  task arr();
    rstb_n_o <= 1'b1;
    gap();
    rsel_n_o <= 1'b1;
    gap();
  endtask : arr
endmodule : ramcol_user

// [sim/ramcol_top_test.sv]
// ramcol_top_test: self-checking bench for the two-port ram block
// assumes: ramcol_user drives the pins; registers reached over apb
`timescale 1ns/100ps
module ramcol_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, write_parity_fault, read_parity_fault, wclk, wstb_n, wpul_n, wsel_n, rclk, rstb_n, rpul_n, rsel_n;
  wire [7:0] wloc, rloc;
  wire [8:0] wdat, rword;
  int fails = 0;
  int n_compared = 0;
  logic [9:0] exp_q[$];
  event rd_ev;
  logic pipe = 1'b0;
  logic podd = 1'b0;
  logic [8:0] last = 9'h000;
  logic [31:0] r;
  logic e;
  logic [7:0] a;
  logic [8:0] d;
  logic [8:0] d2;
  always #12.5 clk = ~clk;
  ramcol_top DUT (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(1'b1), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .WRITE_SIDE_CLOCK_I(wclk),
    .WRITE_STROBE_N_I(wstb_n), .WRITE_PULSE_N_I(wpul_n), .WRITE_SELECT_N_I(wsel_n),
    .WRITE_LOCATION_I(wloc), .WRITE_WORD_IN_I(wdat), .WRITE_PARITY_FAULT_O(write_parity_fault),
    .READ_SIDE_CLOCK_I(rclk), .READ_STROBE_N_I(rstb_n), .READ_PULSE_N_I(rpul_n),
    .READ_SELECT_N_I(rsel_n), .READ_LOCATION_I(rloc), .READ_WORD_O(rword),
    .READ_PARITY_FAULT_O(read_parity_fault));
  ramcol_user U (.clk_i(clk), .wclk_o(wclk), .wstb_n_o(wstb_n), .wpul_n_o(wpul_n),
    .wsel_n_o(wsel_n), .wloc_o(wloc), .wdat_o(wdat), .rclk_o(rclk), .rstb_n_o(rstb_n),
    .rpul_n_o(rpul_n), .rsel_n_o(rsel_n), .rloc_o(rloc));
  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task cmp(input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask : cmp
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task ctrl(input logic [4:0] c);
    apb(1'b1, 8'h00, {27'h0, c});
    pipe = c[2];
    podd = c[4];
  endtask : ctrl
  // the monitor compares each note with the shown word and flag
  task chk(input logic [8:0] w);
    exp_q.push_back({(^w) ^ podd, w});
    -> rd_ev;
  endtask : chk
  always @(rd_ev) cmp(32'(exp_q.pop_front()), {22'h0, read_parity_fault, rword});
  task res(input logic [7:0] ra, input logic [8:0] cur);
    if (pipe) begin
      chk(last);
      U.cyc(1'b0, 1'b1, ra, ra, 9'h000);
    end
    chk(cur);
    last = cur;
  endtask : res
  initial begin
    void'($urandom(45));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    U.gap();
    apb(1'b0, 8'h00, 32'h0);
    cmp(32'h0, r);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    cmp(32'h1, {31'h0, e});
    for (int m = 0; m < 4; m++) begin
      ctrl({m[1], 1'b0, m[0], 2'b00});
      a = 8'($urandom);
      d = 9'($urandom);
      d2 = 9'($urandom);
      U.cyc(1'b1, 1'b1, a, a, d);
      res(a, d);
      U.cyc(1'b1, 1'b0, a, a, d2);
      chk(d);
      U.cyc(1'b0, 1'b1, a, a, 9'h000);
      res(a, d2);
    end
    for (int m = 0; m < 2; m++) begin
      ctrl({2'b00, m[0], 2'b01});
      a = 8'($urandom);
      d = 9'($urandom);
      d2 = 9'($urandom);
      U.awf(a, d);
      cmp({31'h0, ^d}, {31'h0, write_parity_fault});
      U.cyc(1'b0, 1'b1, a, a, 9'h000);
      res(a, d);
      U.awr();
      U.awf(a, d2);
      U.awr();
      chk(d);
      U.cyc(1'b0, 1'b1, a, a, 9'h000);
      res(a, d2);
    end
    ctrl(5'h03);
    U.arf(a);
    chk(d2);
    d = 9'($urandom);
    U.awf(a, d);
    U.awr();
    chk(d);
    U.arr();
    chk(d);
    apb(1'b0, 8'h04, 32'h0);
    cmp({23'h0, d}, {23'h0, r[8:0]});
    ctrl(5'h09);
    U.awf(a, d ^ 9'h100);
    cmp(32'h0, {31'h0, write_parity_fault});
    U.awr();
    ctrl(5'h08);
    U.cyc(1'b0, 1'b1, a, a, 9'h000);
    res(a, {^d[7:0], d[7:0]});
    print_verdict();
  end
endmodule : ramcol_top_test
